// [host_model.sv]
// Host-side model that issues register requests to the display control block.
`include "matrix_cfg.svh"
`default_nettype none
module host_model (
  // Clock
  input wire logic clk,
  // Request lines
  output var logic req_valid,
  output var logic req_write,
  output var matrix_pkg::reg_byte_t req_addr,
  output var matrix_pkg::reg_byte_t req_wdata,
  // Read answer
  input wire matrix_pkg::reg_byte_t rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import matrix_pkg::*;

  // Idle at time zero with the strobe low.
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 8'h00;
    req_wdata = 8'h00;
  end

  // One request held over exactly one taking edge; released lines show the inverse so
  // that a design latching stale values cannot pass by luck.
  task automatic issue(input logic w, input reg_byte_t a, input reg_byte_t d);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    req_write <= ~w;
    req_addr <= ~a;
    req_wdata <= ~d;
  endtask

  // Read with a bounded wait for the answer strobe.
  task automatic rd(input reg_byte_t a, output reg_byte_t d, output bit ok);
    issue(1'b0, a, 8'h00);
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        d = rd_data;
      end else begin
        @(posedge clk);
      end
    end
  endtask

  task automatic glyph_ptr(input reg_byte_t p);
    issue(1'b1, `ADDR_GLYPH, p | 8'h80);
  endtask

  task automatic glyph_col(input reg_byte_t c);
    issue(1'b1, `ADDR_GLYPH, c & 8'h7f);
  endtask
endmodule // host_model
`default_nettype wire

// [matrix_cfg.svh]
// Offsets, field positions, reset values and timing counts of the display control registers.
`ifndef MATRIX_CFG_SVH
`define MATRIX_CFG_SVH

`define ADDR_BRIGHT01 8'h01
`define ADDR_BRIGHT23 8'h02
`define ADDR_SCAN 8'h03
`define ADDR_GLYPH 8'h05
`define ADDR_TEST 8'h07

`define BRIGHT_RST 8'h00
`define SCAN_RST 8'h00
`define TEST_RST 1'b0
`define PTR_BASE 8'h80
`define PTR_LAST 8'hf7
`define PTR_INVALID 8'hf8

`define PTR_CMD_BIT 7
`define SCAN_FOUR_BIT 0
`define TEST_BIT 0
`define GLYPH_DEPTH 120

`define TEST_ON_STEPS 4'h7
`define ON_STEPS_MAX 4'hf
`define ON_CLAMP_CODE 4'he

`define CLK_PERIOD_NS 10
`define PWM_STEP_NS 1000
`define PWM_STEP_CYCLES ((`PWM_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [matrix_display_control_regs.sv]
// Control registers, user glyph store and display outputs of the dot-matrix driver.
`include "matrix_cfg.svh"
`default_nettype none
module matrix_display_control_regs #(
  parameter int STEP_CYCLES = `PWM_STEP_CYCLES,
  parameter int GLYPH_DEPTH = `GLYPH_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register request port from the serial front end
  input wire logic req_valid,
  input wire logic req_write,
  input wire matrix_pkg::reg_byte_t req_addr,
  input wire matrix_pkg::reg_byte_t req_wdata,
  output var matrix_pkg::reg_byte_t rd_data,
  output var logic rd_valid,
  // Shutdown level from the shutdown control
  input wire logic shutdown,
  // Display drive
  output var logic [7:0] digit_drive,
  output var logic leds_all_on,
  output var matrix_pkg::reg_byte_t glyph_pointer
);
  import matrix_pkg::*;

  logic rst_meta_q;
  logic rst_n;
  reg_byte_t bright01_q;
  reg_byte_t bright23_q;
  reg_byte_t scan_q;
  logic test_q;
  reg_byte_t ptr_q;
  logic [6:0] font_q [GLYPH_DEPTH];
  logic [7:0] drive_q;
  logic all_on_q;
  reg_byte_t rd_data_q;
  logic rd_valid_q;
  logic wr_any;
  logic glyph_cmd;
  logic glyph_data_wr;
  logic glyph_rd;
  reg_byte_t rd_data_d;

  scan_if sif ();

  // Pointer step after a data access; the last slot wraps to the first.
  function automatic reg_byte_t ptr_advance(input reg_byte_t p);
    if (p == `PTR_LAST) return `PTR_BASE;
    return p + 8'h01;
  endfunction

  // Pointer load value; an out-of-range base would address nothing, so it is clamped.
  function automatic reg_byte_t ptr_load(input reg_byte_t v);
    if (v >= `PTR_INVALID) return `PTR_BASE;
    return v;
  endfunction

  // Reset release is synchronised; assertion stays asynchronous.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Request decode.
  assign wr_any = req_valid && req_write;
  assign glyph_cmd = wr_any && req_addr == `ADDR_GLYPH && req_wdata[`PTR_CMD_BIT];
  assign glyph_data_wr = wr_any && req_addr == `ADDR_GLYPH && !req_wdata[`PTR_CMD_BIT];
  assign glyph_rd = req_valid && !req_write && req_addr == `ADDR_GLYPH;

  // Brightness registers; one nibble per digit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bright01_q <= `BRIGHT_RST;
      bright23_q <= `BRIGHT_RST;
    end else if (wr_any) begin
      if (req_addr == `ADDR_BRIGHT01) begin
        bright01_q <= req_wdata;
      end
      if (req_addr == `ADDR_BRIGHT23) begin
        bright23_q <= req_wdata;
      end
    end
  end

  // Scan limit; only bit zero steers the scanner, the rest is held for read-back.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_q <= `SCAN_RST;
    end else if (wr_any && req_addr == `ADDR_SCAN) begin
      scan_q <= req_wdata;
    end
  end

  // Display-test mode bit; it overrides the display without touching other state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_q <= `TEST_RST;
    end else if (wr_any && req_addr == `ADDR_TEST) begin
      test_q <= req_wdata[`TEST_BIT];
    end
  end

  // Font pointer: loaded by command writes, advanced by every data access.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= `PTR_BASE;
    end else if (glyph_cmd) begin
      ptr_q <= ptr_load(req_wdata);
    end else if (glyph_data_wr || glyph_rd) begin
      ptr_q <= ptr_advance(ptr_q);
    end
  end

  // Glyph store; the pointer never leaves 0x80..0xf7, so its low bits index directly.
  // It has no reset: the store is plain memory, written before use.
  always_ff @(posedge clk) begin
    if (glyph_data_wr) begin
      font_q[ptr_q[6:0]] <= req_wdata[6:0];
    end
  end

  // Read mux; reserved bits of the test register read as zero.
  always_comb begin
    rd_data_d = 8'h00;
    unique case (req_addr)
      `ADDR_BRIGHT01: rd_data_d = bright01_q;
      `ADDR_BRIGHT23: rd_data_d = bright23_q;
      `ADDR_SCAN: rd_data_d = scan_q;
      `ADDR_GLYPH: rd_data_d = {1'b0, font_q[ptr_q[6:0]]};
      `ADDR_TEST: rd_data_d = {7'h00, test_q};
      default: rd_data_d = 8'h00;
    endcase
  end

  // Read answer one cycle after the request.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= req_valid && !req_write;
      if (req_valid && !req_write) begin
        rd_data_q <= rd_data_d;
      end
    end
  end

  // Scanner configuration; shutdown blanks only normal operation.
  assign sif.bright01 = bright01_q;
  assign sif.bright23 = bright23_q;
  assign sif.scan_four = scan_q[`SCAN_FOUR_BIT];
  assign sif.test_on = test_q;
  assign sif.blank = shutdown;

  mux_scan #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_scan (
    .clk(clk),
    .rst_n(rst_n),
    .sif(sif.scan)
  );

  // Output flops keep the pins glitch-free while the scanner decodes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_q <= 8'h00;
      all_on_q <= 1'b0;
    end else begin
      drive_q <= sif.drive;
      all_on_q <= test_q;
    end
  end

  assign digit_drive = drive_q;
  assign leds_all_on = all_on_q;
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign glyph_pointer = ptr_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ptr_cmd_load: assert property (glyph_cmd && req_wdata < `PTR_INVALID
      |=> ptr_q == $past(req_wdata))
    else $error("pointer not loaded from command write");
  a_ptr_cmd_clamp: assert property (glyph_cmd && req_wdata >= `PTR_INVALID
      |=> ptr_q == `PTR_BASE)
    else $error("invalid pointer not forced to base");
  a_ptr_step: assert property (glyph_data_wr && ptr_q != `PTR_LAST
      |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance by one");
  a_ptr_wrap: assert property ((glyph_data_wr || glyph_rd) && ptr_q == `PTR_LAST
      |=> ptr_q == `PTR_BASE)
    else $error("pointer did not wrap to base");
  a_glyph_store: assert property (glyph_data_wr
      |=> font_q[$past(ptr_q[6:0])] == $past(req_wdata[6:0]))
    else $error("column pattern not stored at pointer");
  // Case equality because the store is not reset and may still hold unknown dots.
  a_cmd_no_store: assert property (glyph_cmd
      |=> font_q[$past(ptr_q[6:0])] === $past(font_q[ptr_q[6:0]]))
    else $error("pointer write altered glyph data");
  // The host leaves one idle cycle between requests, so columns arrive every other edge.
  a_five_col_char: assert property (glyph_cmd && req_wdata == 8'h8a ##2 glyph_data_wr
      ##2 glyph_data_wr ##2 glyph_data_wr ##2 glyph_data_wr ##2 glyph_data_wr
      |=> ptr_q == 8'h8f)
    else $error("five columns did not leave pointer at next base");
  a_test_keeps_regs: assert property (wr_any && req_addr == `ADDR_TEST |=> $stable(bright01_q)
      && $stable(bright23_q) && $stable(scan_q) && $stable(ptr_q))
    else $error("test write disturbed other registers");
  a_test_lights_all: assert property (wr_any && req_addr == `ADDR_TEST
      && req_wdata[`TEST_BIT] |=> ##1 leds_all_on)
    else $error("test mode did not light all LEDs");
  a_nibble_digit0: assert property (wr_any && req_addr == `ADDR_BRIGHT01
      |=> sif.bright01[3:0] == $past(req_wdata[3:0]))
    else $error("lower nibble not routed to digit zero");
  a_upper_nibble: assert property (wr_any && req_addr == `ADDR_BRIGHT23
      |=> bright23_q == $past(req_wdata))
    else $error("brightness for digits two and three not stored");
  a_glyph_read_msb: assert property (glyph_rd |=> rd_valid && !rd_data[7])
    else $error("glyph read answer missing or bit seven set");
  a_read_step: assert property (glyph_rd && ptr_q != `PTR_LAST
      |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance after a glyph read");
  a_test_bit_taken: assert property (wr_any && req_addr == `ADDR_TEST
      |=> test_q == $past(req_wdata[`TEST_BIT]))
    else $error("test mode bit not taken from bit zero");
  a_all_on_follows: assert property (test_q |=> leds_all_on)
    else $error("all-on output missing in test mode");
  a_all_on_clear: assert property (!test_q |=> !leds_all_on)
    else $error("all-on output set in normal operation");

  c_char_loaded: cover property (glyph_data_wr && ptr_q == 8'h8e);
  c_ptr_wrap: cover property (glyph_data_wr && ptr_q == `PTR_LAST);
  c_test_in_shutdown: cover property (test_q && shutdown && |digit_drive);
endmodule // matrix_display_control_regs
`default_nettype wire

// [matrix_pkg.sv]
// Types shared by the display control block and its multiplex scanner.
`default_nettype none
package matrix_pkg;
  // Multiplex time slot; Gray coded along the scan order.
  typedef enum logic [1:0] {
    SLOT_D01 = 2'b00,
    SLOT_D23 = 2'b01,
    SLOT_D45 = 2'b11,
    SLOT_D67 = 2'b10
  } slot_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [3:0] pwm_step_t;
endpackage
`default_nettype wire

// [mux_scan.sv]
// Multiplex slot sequencer and per-digit pulse-width modulator.
`include "matrix_cfg.svh"
`default_nettype none
module mux_scan #(
  parameter int STEP_CYCLES = `PWM_STEP_CYCLES
) (
  // Clock and synchronised reset
  input wire logic clk,
  input wire logic rst_n,
  // Register side
  scan_if.scan sif
);
  import matrix_pkg::*;

  slot_t slot_q;
  pwm_step_t phase_q;
  logic [15:0] div_q;
  logic [3:0] on_steps [4];
  logic step_end;

  // Brightness code to on-steps; the two top codes share the maximum.
  function automatic pwm_step_t on_count(input logic [3:0] code);
    if (code >= `ON_CLAMP_CODE) return `ON_STEPS_MAX;
    return code + 4'h1;
  endfunction

  assign step_end = (div_q == 16'(STEP_CYCLES - 1));

  // Prescaler sets the length of one sixteenth of a slot.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= step_end ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // Sixteen phases make one slot.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 4'h0;
    end else if (step_end) begin
      phase_q <= phase_q + 4'h1;
    end
  end

  // Slot order; a scan-limit change mid-scan falls back to the first pair.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_q <= SLOT_D01;
    end else if (step_end && phase_q == 4'hf) begin
      unique case (slot_q)
        SLOT_D01: slot_q <= (sif.test_on || sif.scan_four) ? SLOT_D23 : SLOT_D01;
        SLOT_D23: slot_q <= sif.test_on ? SLOT_D45 : SLOT_D01;
        SLOT_D45: slot_q <= sif.test_on ? SLOT_D67 : SLOT_D01;
        SLOT_D67: slot_q <= SLOT_D01;
      endcase
    end
  end

  assign on_steps[0] = on_count(sif.bright01[3:0]);
  assign on_steps[1] = on_count(sif.bright01[7:4]);
  assign on_steps[2] = on_count(sif.bright23[3:0]);
  assign on_steps[3] = on_count(sif.bright23[7:4]);

  // Digit enables; test mode overrides limit, brightness and blanking.
  for (genvar g = 0; g < 8; g++) begin : g_drive
    if (g < 4) begin : g_user
      assign sif.drive[g] = sif.test_on ? (slot_q == slot_t'(g / 2 == 0 ? SLOT_D01 : SLOT_D23)
                                           && phase_q < `TEST_ON_STEPS)
                          : (!sif.blank && (g < 2 || sif.scan_four)
                             && slot_q == (g < 2 ? SLOT_D01 : SLOT_D23)
                             && phase_q < on_steps[g]);
    end else begin : g_test
      assign sif.drive[g] = sif.test_on && slot_q == (g < 6 ? SLOT_D45 : SLOT_D67)
                            && phase_q < `TEST_ON_STEPS;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_test_duty_cap: assert property (sif.test_on && phase_q >= `TEST_ON_STEPS |-> sif.drive == 8'h00)
    else $error("test mode drove past 7/16");
  a_two_digit_only: assert property (!sif.test_on && !sif.scan_four |-> sif.drive[7:2] == 6'h00)
    else $error("digits above one driven with two-digit limit");
  a_pairs_apart: assert property (!(|sif.drive[1:0] && |sif.drive[3:2]))
    else $error("both digit pairs driven together");
  a_max_on_time: assert property (!sif.test_on && phase_q == 4'hf |-> sif.drive == 8'h00)
    else $error("digit driven in the blanking sixteenth");
  a_four_digit_reach: assert property (!sif.test_on && sif.scan_four && !sif.blank
      && slot_q == SLOT_D23 && phase_q == 4'h0 |-> sif.drive[3:2] == 2'b11)
    else $error("upper pair idle with four-digit limit");
  c_upper_slot: cover property (sif.drive[3]);
  c_test_eighth: cover property (sif.drive[7]);
endmodule // mux_scan
`default_nettype wire

// [scan_if.sv]
// Carrier between the control registers and the multiplex scanner.
`default_nettype none
interface scan_if;
  matrix_pkg::reg_byte_t bright01;
  matrix_pkg::reg_byte_t bright23;
  logic scan_four;
  logic test_on;
  logic blank;
  logic [7:0] drive;
  modport ctrl (output bright01, output bright23, output scan_four, output test_on,
                output blank, input drive);
  modport scan (input bright01, input bright23, input scan_four, input test_on,
                input blank, output drive);
endinterface
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the display control registers.
`include "matrix_cfg.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import matrix_pkg::*;
  localparam int STEP = 2;
  logic clk;
  logic arst_n;
  logic shutdown;
  logic req_valid;
  logic req_write;
  reg_byte_t req_addr;
  reg_byte_t req_wdata;
  reg_byte_t rd_data;
  reg_byte_t glyph_pointer;
  logic rd_valid;
  logic leds_all_on;
  logic [7:0] digit_drive;
  int err_total;
  int samples_checked;
  int overlap;
  int cnt [8];
  logic [31:0] seed;
  reg_byte_t got, v, w, s, b;
  reg_byte_t col [5];
  bit ok;

  matrix_display_control_regs #(.STEP_CYCLES(STEP), .GLYPH_DEPTH(120)) dut (
    .clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
    .shutdown(shutdown), .digit_drive(digit_drive), .leds_all_on(leds_all_on),
    .glyph_pointer(glyph_pointer));

  host_model host (
    .clk(clk), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rd_data(rd_data), .rd_valid(rd_valid));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Verdict and end of run.
  task automatic finish_test;
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Eight LFSR steps per byte so successive bytes are not shifted copies.
  function automatic reg_byte_t rnd();
    repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  // A lost read answer counts as a mismatch and ends the run.
  task automatic rd_check(input reg_byte_t a, input reg_byte_t e);
    host.rd(a, got, ok);
    if (!ok) begin
      err_total++;
      finish_test();
    end else begin
      check({8'h00, got}, {8'h00, e});
    end
  endtask

  // Lit cycles per slot visit times visits; codes 14 and 15 share the ceiling.
  function automatic int on_cycles(input logic [3:0] n, input int visits);
    return visits * STEP * ((n >= `ON_CLAMP_CODE) ? 15 : n + 1);
  endfunction

  // Counts lit cycles per digit over 256 cycles, a whole number of frames in every mode.
  task automatic measure;
    overlap = 0;
    for (int k = 0; k < 8; k++) cnt[k] = 0;
    repeat (256) begin
      @(posedge clk);
      #1;
      for (int k = 0; k < 8; k++) cnt[k] += (digit_drive[k] === 1'b1);
      if (digit_drive[1:0] !== 2'b00 && digit_drive[3:2] !== 2'b00) overlap++;
    end
  endtask

  // Main sequence.
  initial begin
    arst_n = 1'b0;
    shutdown = 1'b0;
    err_total = 0;
    samples_checked = 0;
    seed = 32'h9e97e82d;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1 check({8'h00, glyph_pointer}, 16'h0080);
    // Reset values, then an unmapped address that must answer zero.
    for (int i = 1; i < 5; i++) rd_check(8'(i), 8'h00);
    // Random write and read back of every plain register.
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      host.issue(1'b1, 8'(1 + i % 3), v);
      rd_check(8'(1 + i % 3), v);
    end
    // Load one whole character starting at the third base.
    col[0] = 8'h42;
    for (int i = 1; i < 5; i++) col[i] = rnd();
    host.glyph_ptr(8'h8a);
    #1 check({8'h00, glyph_pointer}, 16'h008a);
    for (int i = 0; i < 5; i++) begin
      host.glyph_col(col[i]);
      #1 check({8'h00, glyph_pointer}, {8'h00, 8'h8b + 8'(i)});
    end
    host.glyph_ptr(8'h8a);
    for (int i = 0; i < 5; i++) rd_check(`ADDR_GLYPH, col[i] & 8'h7f);
    // Wrap after the last place, and clamp of every invalid pointer value.
    host.glyph_ptr(8'hf7);
    host.glyph_col(8'h15);
    #1 check({8'h00, glyph_pointer}, 16'h0080);
    for (int i = 0; i < 8; i++) begin
      host.glyph_ptr(8'hf8 + 8'(i));
      #1 check({8'h00, glyph_pointer}, 16'h0080);
    end
    // Normal scanning: four digits with corner codes, two digits, then shutdown.
    for (int c = 0; c < 5; c++) begin
      v = rnd();
      w = rnd();
      s = rnd();
      if (c == 0) v = 8'he0;
      if (c == 1) w[7:4] = 4'hf;
      s[0] = (c != 3);
      host.issue(1'b1, `ADDR_BRIGHT01, v);
      host.issue(1'b1, `ADDR_BRIGHT23, w);
      host.issue(1'b1, `ADDR_SCAN, s);
      @(posedge clk);
      shutdown <= (c == 4);
      repeat (130) @(posedge clk);
      measure();
      check(16'(overlap), 16'h0000);
      for (int k = 0; k < 8; k++) begin
        b = (k < 2) ? v : w;
        ok = (k < 2 || s[0]) && c != 4 && k < 4;
        check(16'(cnt[k]), ok ? 16'(on_cycles(k[0] ? b[7:4] : b[3:0], s[0] ? 4 : 8)) : 16'h0);
      end
    end
    // Test mode overrides shutdown and leaves the registers alone.
    b = rnd();
    host.issue(1'b1, `ADDR_TEST, b | 8'h01);
    repeat (2) @(posedge clk);
    #1 check({15'h0000, leds_all_on}, 16'h0001);
    repeat (130) @(posedge clk);
    measure();
    for (int k = 0; k < 8; k++) check(16'(cnt[k]), 16'(2 * STEP * 7));
    rd_check(`ADDR_BRIGHT01, v);
    rd_check(`ADDR_BRIGHT23, w);
    rd_check(`ADDR_SCAN, s);
    host.issue(1'b1, `ADDR_TEST, b & 8'hfe);
    repeat (2) @(posedge clk);
    #1 check({15'h0000, leds_all_on}, 16'h0000);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
